// ===== include/codec_seq_defines.vh
`ifndef CODEC_SEQ_DEFINES_VH
`define CODEC_SEQ_DEFINES_VH

// -----------------------------------------------------------------------
// word and sequence sizes
// -----------------------------------------------------------------------
`define WORD_W        8
`define CNT_W         4
`define XMT_CYCLES    4'h9
`define RCV_PULSES    4'h9
`define LAST_BIT      4'h7
`define CNT_ZERO      4'h0
`define WORD_ZERO     8'h00
`define MSB_ONE       8'h80

// -----------------------------------------------------------------------
// sequencer states
// -----------------------------------------------------------------------
`define ST_IDLE       2'h0
`define ST_XMT        2'h1
`define ST_RCV        2'h2
`define ST_HOLD       2'h3

`endif

// ===== rtl/pcm_codec_sequencer.v
`timescale 1ns/1ps
`include "codec_seq_defines.vh"

// Operation
// - serial receive feeds register, comparator isolated
// - encode select low throughout receive
// - register shifts serially, word after eight
// - register frozen, start high while settling
// - single active-low conversion-done output
// - transmit takes nine cycles, ninth reinitialises
// - parallel receive loads register at once, no shift clock
// - serial receive shift takes nine pulses
// - parallel words sign-magnitude, uncomplemented
// - encode select chooses encode or decode
module pcm_codec_sequencer (
   // clock and reset
   input  wire        REF_CLK,
   input  wire        RESET,
   // commands from the communication system
   input  wire        START_N,
   input  wire        TRANSMIT_COMMAND,
   input  wire        RECEIVE_N,
   input  wire        PARALLEL_MODE,
   // data from the link and the comparator
   input  wire        RECEIVE_DATA,
   input  wire [7:0]  RECEIVE_WORD,
   input  wire        COMPARE_IN,
   // converter side
   output wire [7:0]  DAC_WORD,
   output wire        ENCODE_SELECT,
   // results
   output wire        CONVERSION_DONE_N,
   output wire        TRANSMIT_DATA,
   output wire        TRANSMIT_DATA_OE,
   output wire [7:0]  TRANSMIT_WORD
);

   // ---------------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------------
   reg  [2:0]  start_s_q;
   reg  [2:0]  rcv_s_q;
   reg  [2:0]  xmt_s_q;
   reg  [2:0]  par_s_q;
   reg  [7:0]  rword_s1_q;
   reg  [7:0]  rword_s2_q;
   reg  [7:0]  rword_s3_q;
   reg         start_n_f_q;
   reg         rcv_n_f_q;
   reg         xmt_f_q;
   reg         par_f_q;
   reg  [7:0]  rword_f_q;

   // a change counts once stages two and three agree
   function agree;
      input [2:0] s;
      input       prev;
      begin
         agree = (s[1] == s[2]) ? s[2] : prev;
      end
   endfunction

   always @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         start_s_q   <= 3'h7;
         rcv_s_q     <= 3'h7;
         xmt_s_q     <= 3'h0;
         par_s_q     <= 3'h0;
         rword_s1_q  <= `WORD_ZERO;
         rword_s2_q  <= `WORD_ZERO;
         rword_s3_q  <= `WORD_ZERO;
         start_n_f_q <= 1'b1;
         rcv_n_f_q   <= 1'b1;
         xmt_f_q     <= 1'b0;
         par_f_q     <= 1'b0;
         rword_f_q   <= `WORD_ZERO;
      end else begin
         start_s_q   <= {start_s_q[1:0], START_N};
         rcv_s_q     <= {rcv_s_q[1:0], RECEIVE_N};
         xmt_s_q     <= {xmt_s_q[1:0], TRANSMIT_COMMAND};
         par_s_q     <= {par_s_q[1:0], PARALLEL_MODE};
         rword_s1_q  <= RECEIVE_WORD;
         rword_s2_q  <= rword_s1_q;
         rword_s3_q  <= rword_s2_q;
         // a one-clock start pulse never sits in two stages at once,
         // so it is taken from stage three without the agreement test
         start_n_f_q <= start_s_q[2];
         rcv_n_f_q   <= agree(rcv_s_q, rcv_n_f_q);
         xmt_f_q     <= agree(xmt_s_q, xmt_f_q);
         par_f_q     <= agree(par_s_q, par_f_q);
         // word only taken when two stages agree in full
         if (rword_s2_q == rword_s3_q) begin
            rword_f_q <= rword_s3_q;
         end
      end
   end

   // ---------------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------------
   reg  [1:0]  state_q;
   reg  [1:0]  state_d;
   reg  [3:0]  cnt_q;
   reg  [3:0]  cnt_d;
   reg  [7:0]  approximation_register_q;
   reg  [7:0]  approximation_register_d;
   reg  [7:0]  result_q;
   reg  [7:0]  result_d;
   reg         done_n_q;
   reg         done_n_d;
   reg         mode_q;
   reg         mode_d;
   reg         serial_bit_q;
   reg         serial_bit_d;

   // trial bit mask for the bit under test, msb first
   function [7:0] trial_mask;
      input [3:0] idx;
      begin
         trial_mask = `MSB_ONE >> idx;
      end
   endfunction

   // next-state and datapath decisions
   always @* begin
      state_d                  = state_q;
      cnt_d                    = cnt_q;
      approximation_register_d = approximation_register_q;
      result_d                 = result_q;
      done_n_d                 = done_n_q;
      mode_d                   = mode_q;
      serial_bit_d             = serial_bit_q;
      case (state_q)
         `ST_IDLE: begin
            // start has priority; receive is taken only while start is idle high
            if (!rcv_n_f_q && start_n_f_q) begin
               mode_d   = 1'b0;
               cnt_d    = `CNT_ZERO;
               done_n_d = 1'b1;
               if (par_f_q) begin
                  // parallel word goes straight to the converter
                  approximation_register_d = rword_f_q;
                  state_d = `ST_HOLD;
               end else begin
                  state_d = `ST_RCV;
               end
            end else if (!start_n_f_q) begin
               mode_d   = 1'b1;
               cnt_d    = `CNT_ZERO;
               done_n_d = 1'b1;
               approximation_register_d = `MSB_ONE;
               state_d  = `ST_XMT;
            end
         end
         `ST_XMT: begin
            if (cnt_q <= `LAST_BIT) begin
               // keep or drop the trial bit, then try the next one
               // comparator settles inside one clock, so it is read unsynchronised
               serial_bit_d = COMPARE_IN;
               approximation_register_d = (approximation_register_q
                  & ~(COMPARE_IN ? `WORD_ZERO : trial_mask(cnt_q)))
                  | trial_mask(cnt_q + 4'h1);
               if (cnt_q == `LAST_BIT) begin
                  result_d = approximation_register_q
                     & ~(COMPARE_IN ? `WORD_ZERO : trial_mask(cnt_q));
                  done_n_d = 1'b0;
               end
               cnt_d = cnt_q + 4'h1;
            end else begin
               // ninth cycle readies the register for the next pass
               approximation_register_d = `WORD_ZERO;
               cnt_d   = `CNT_ZERO;
               state_d = `ST_IDLE;
            end
         end
         `ST_RCV: begin
            // serial stream shares this clock, so each bit is taken directly
            approximation_register_d =
               {approximation_register_q[6:0], RECEIVE_DATA};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == `RCV_PULSES - 4'h2) begin
               done_n_d = 1'b0;
            end
            if (cnt_q == `RCV_PULSES - 4'h1) begin
               // ninth pulse ends shifting, the word is then held
               approximation_register_d = approximation_register_q;
               state_d = `ST_HOLD;
            end
         end
         default: begin
            // settling: register frozen until receive is released
            if (rcv_n_f_q) begin
               done_n_d = 1'b1;
               mode_d   = 1'b1;
               state_d  = `ST_IDLE;
            end
         end
      endcase
   end

   always @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         state_q                  <= `ST_IDLE;
         cnt_q                    <= `CNT_ZERO;
         approximation_register_q <= `WORD_ZERO;
         result_q                 <= `WORD_ZERO;
         done_n_q                 <= 1'b1;
         mode_q                   <= 1'b1;
         serial_bit_q             <= 1'b0;
      end else begin
         state_q                  <= state_d;
         cnt_q                    <= cnt_d;
         approximation_register_q <= approximation_register_d;
         result_q                 <= result_d;
         done_n_q                 <= done_n_d;
         mode_q                   <= mode_d;
         serial_bit_q             <= serial_bit_d;
      end
   end

   // ---------------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------------
   // encode select picks encode when high, decode when low
   assign ENCODE_SELECT     = mode_q;
   assign DAC_WORD          = approximation_register_q;
   assign CONVERSION_DONE_N = done_n_q;
   assign TRANSMIT_WORD     = result_q;
   assign TRANSMIT_DATA     = serial_bit_q;
   // transmit buffer only while commanded with encode select high, so it stays quiet in receive
   assign TRANSMIT_DATA_OE  = xmt_f_q & mode_q;

endmodule

// ===== verif/codec_seq_monitor.sv
`timescale 1ns/1ps
module codec_seq_monitor (
   // watched ports of the sequencer
   input wire logic       REF_CLK, RESET, START_N, TRANSMIT_COMMAND, RECEIVE_N, PARALLEL_MODE,
   input wire logic       RECEIVE_DATA, COMPARE_IN, ENCODE_SELECT, CONVERSION_DONE_N,
   input wire logic       TRANSMIT_DATA, TRANSMIT_DATA_OE,
   input wire logic [7:0] RECEIVE_WORD, DAC_WORD, TRANSMIT_WORD
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   // ----------------------------------------------------------------
   // transmit steps, then reset, transmit and receive checks
   // ----------------------------------------------------------------
   // first trial of an encode: msb alone, straight after an idle zero word
   sequence xmt_first;
      ENCODE_SELECT && DAC_WORD == 8'h80 && $past(DAC_WORD) == 8'h00;
   endsequence
   sequence xmt_count;
      ##1 CONVERSION_DONE_N [*7] ##1 !CONVERSION_DONE_N;
   endsequence
   // reset must override, so this one is not disabled by it
   a_reset_outputs: assert property (disable iff (1'b0) RESET |=> CONVERSION_DONE_N &&
      ENCODE_SELECT && !TRANSMIT_DATA_OE && DAC_WORD == 8'h00) else $error("bad reset outputs");
   a_xmt_nine_cycles: assert property (xmt_first |-> xmt_count)
      else $error("encode length wrong");
   a_xmt_reinit: assert property ($fell(CONVERSION_DONE_N) && ENCODE_SELECT |=>
      DAC_WORD == 8'h00) else $error("register not reinitialised");
   a_msb_first: assert property (xmt_first |=> DAC_WORD[7] == $past(COMPARE_IN) &&
      DAC_WORD[6] && TRANSMIT_DATA == $past(COMPARE_IN)) else $error("msb trial wrong");
   a_rcv_decode: assert property ((!RECEIVE_N) [*6] |-> !ENCODE_SELECT)
      else $error("encode select high in receive");
   a_rcv_frozen: assert property (!CONVERSION_DONE_N && !ENCODE_SELECT && !RECEIVE_N |=>
      $stable(DAC_WORD)) else $error("word moved while settling");
   a_par_no_done: assert property ($fell(CONVERSION_DONE_N) |-> ENCODE_SELECT ||
      !PARALLEL_MODE) else $error("done in parallel receive");
   a_par_load: assert property ((PARALLEL_MODE && !RECEIVE_N && $stable(RECEIVE_WORD)) [*8]
      |-> DAC_WORD == RECEIVE_WORD) else $error("parallel word not loaded");
   a_oe_off: assert property ((!TRANSMIT_COMMAND) [*6] |-> !TRANSMIT_DATA_OE)
      else $error("transmit driver on without command");
endmodule

bind pcm_codec_sequencer codec_seq_monitor mon (.*);

// ===== verif/pcm_link_model.sv
`timescale 1ns/1ps
module pcm_link_model (
   input  wire logic       REF_CLK,
   input  wire logic       CONVERSION_DONE_N,
   input  wire logic       ENCODE_SELECT,
   input  wire logic [7:0] DAC_WORD,
   output logic            START_N, TRANSMIT_COMMAND, RECEIVE_N, PARALLEL_MODE, RECEIVE_DATA,
   output logic      [7:0] RECEIVE_WORD,
   output wire logic       COMPARE_IN
);
   logic [7:0] level = 8'h00;
   // comparator: keep the trial bit while it does not exceed the held sample
   assign COMPARE_IN = (DAC_WORD <= level);
   initial begin
      {START_N, TRANSMIT_COMMAND, RECEIVE_N, PARALLEL_MODE, RECEIVE_DATA} = 5'b10100;
      RECEIVE_WORD = 8'h00;
   end
   // bounded wait for a high-to-low change of the done flag
   task automatic wait_fall(output bit late);
      bit hi;
      late = 1;
      hi = 0;
      for (int n = 0; n < 40 && late; n++) begin
         @(negedge REF_CLK);
         if (hi && CONVERSION_DONE_N === 1'b0) late = 0;
         hi = (CONVERSION_DONE_N === 1'b1);
      end
   endtask
   task automatic transmit(input logic [7:0] sample, output bit late);
      level = sample;
      @(negedge REF_CLK) START_N = 0;
      @(negedge REF_CLK) begin
         START_N = 1;
         TRANSMIT_COMMAND = 1;
      end
      wait_fall(late);
   endtask
   task automatic receive_serial(input logic [7:0] word, output bit late);
      PARALLEL_MODE = 0;
      late = 1;
      @(negedge REF_CLK) RECEIVE_N = 0;
      for (int n = 0; n < 20 && late; n++) @(negedge REF_CLK) late = (ENCODE_SELECT !== 1'b0);
      for (int n = 7; n >= 0; n--) begin
         RECEIVE_DATA = word[n];
         @(negedge REF_CLK);
      end
      // line turns to the inverse after the frame so a stale bit cannot pass
      RECEIVE_DATA = ~word[0];
      repeat (4) @(negedge REF_CLK);
   endtask
   task automatic receive_parallel(input logic [7:0] word);
      PARALLEL_MODE = 1;
      RECEIVE_WORD = word;
      @(negedge REF_CLK) RECEIVE_N = 0;
      repeat (10) @(negedge REF_CLK);
   endtask
   task automatic finish;
      @(negedge REF_CLK) begin
         TRANSMIT_COMMAND = 0;
         RECEIVE_N = 1;
      end
      repeat (12) @(negedge REF_CLK);
   endtask
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic       REF_CLK = 0, RESET = 1;
   wire        sn, xc, rn, pm, rd, ci, es, dn, td, oe;
   wire  [7:0] rw, dw, tw;
   int         errors = 0, cmp_count = 0;
   bit         late;
   initial forever #5 REF_CLK = ~REF_CLK;
   pcm_link_model link (.REF_CLK(REF_CLK), .CONVERSION_DONE_N(dn), .ENCODE_SELECT(es),
      .DAC_WORD(dw), .START_N(sn), .TRANSMIT_COMMAND(xc), .RECEIVE_N(rn), .PARALLEL_MODE(pm),
      .RECEIVE_DATA(rd), .RECEIVE_WORD(rw), .COMPARE_IN(ci));
   pcm_codec_sequencer DUT (.REF_CLK(REF_CLK), .RESET(RESET), .START_N(sn), .TRANSMIT_COMMAND(xc),
      .RECEIVE_N(rn), .PARALLEL_MODE(pm), .RECEIVE_DATA(rd), .RECEIVE_WORD(rw), .COMPARE_IN(ci),
      .DAC_WORD(dw), .ENCODE_SELECT(es), .CONVERSION_DONE_N(dn), .TRANSMIT_DATA(td),
      .TRANSMIT_DATA_OE(oe), .TRANSMIT_WORD(tw));
   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      cmp_count++;
      if (seen !== want) begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic complete_run;
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // a wait that ran out ends the run at once
   task automatic judge(input bit lost);
      if (lost) begin
         check(8'h01, 8'h00);
         complete_run;
      end
   endtask
   task automatic test_reset;
      check(dw, 8'h00);
      check({7'h00, es}, 8'h01);
      check({7'h00, dn, oe}, 8'h02);
      check(tw, 8'h00);
   endtask
   task automatic test_transmit;
      logic [7:0] lv [4] = '{8'h00, 8'hFF, 8'h5A, 8'h80};
      foreach (lv[i]) begin
         link.transmit(lv[i], late);
         judge(late);
         check(tw, lv[i]);
         check({7'h00, td}, {7'h00, lv[i][0]});
         check({6'h00, oe, es}, 8'h03);
         link.finish();
         check(dw, 8'h00);
      end
   endtask
   task automatic test_serial;
      logic [7:0] wv [2] = '{8'hA5, 8'h01};
      foreach (wv[i]) begin
         link.receive_serial(wv[i], late);
         judge(late);
         check(dw, wv[i]);
         check({6'h00, dn, es}, 8'h00);
         link.finish();
      end
   endtask
   task automatic test_parallel;
      link.receive_parallel(8'hC3);
      check(dw, 8'hC3);
      check({7'h00, es}, 8'h00);
      link.finish();
   endtask
   // main sequence: reset held five cycles, then each scenario in turn
   initial begin
      repeat (5) @(negedge REF_CLK);
      test_reset();
      RESET = 0;
      repeat (6) @(negedge REF_CLK);
      test_transmit();
      test_serial();
      test_parallel();
      test_transmit();
      complete_run();
   end
endmodule
